// File: logic/mpio_port_unit.sv
// digital port unit: eight ports, direction, pin function select, register port
// How it works
// RL1 - port 0 per-bit direction, realtime pulse select
// RL2 - port 2 input only, feeds interrupt requests
// RL3 - port 3 bits pick port or serial
// RL4 - port 4 direction set for whole byte
// RL5 - expansion mode: port 4 is address/data
// RL6 - port 5 drives upper address in expansion
// RL7 - unused upper address bits stay port bits
// RL8 - port 7 input only, feeds analog inputs
// RL9 - port 8 bits pick port or timer
// RL10 - port 9 bits 0/1 strobes in expansion
// RL11 - fetch mode: port 9 bits 2/3 strobe, mode
// RL12 - after reset all pins undriven, inputs
// RL13 - read gives pin if input, latch if output
`timescale 1ns/1ns
module mpio_port_unit (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [7:0] p0_in,
    output logic [7:0] p0_out,
    output logic [7:0] p0_oe,
    input wire logic [7:0] p2_in,
    input wire logic [4:0] p3_in,
    output logic [4:0] p3_out,
    output logic [4:0] p3_oe,
    input wire logic [7:0] p4_in,
    output logic [7:0] p4_out,
    output logic [7:0] p4_oe,
    input wire logic [7:0] p5_in,
    output logic [7:0] p5_out,
    output logic [7:0] p5_oe,
    input wire logic [7:0] p7_in,
    input wire logic [5:0] p8_in,
    output logic [5:0] p8_out,
    output logic [5:0] p8_oe,
    input wire logic [3:0] p9_in,
    output logic [3:0] p9_out,
    output logic [3:0] p9_oe,
    input wire logic [7:0] realtime_pulse_out,
    output logic nmi_req,
    output logic [5:0] ext_irq_in,
    output logic ext_irq_or_timer_in,
    output logic [7:0] analog_in,
    input wire logic [4:0] serial_ctl_out,
    input wire logic [4:0] serial_ctl_oe,
    output logic [4:0] serial_ctl_in,
    input wire logic [3:0] timer0_pulse_out,
    input wire logic [1:0] timer1_pulse_out,
    input wire logic [15:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_addr_phase,
    input wire logic bus_data_oe,
    output logic [7:0] bus_rdata,
    input wire logic bus_rd_strobe,
    input wire logic bus_wr_strobe,
    input wire logic fetch_addr_strobe,
    input wire logic fetch_mode_out,
    output logic mem_exp_active,
    output logic mem_fetch_active
);

    // ************************************************************
    // pin select and mode registers
    // ************************************************************
    logic [7:0] p0_alt;
    logic [4:0] p3_alt;
    logic [5:0] p8_alt;
    logic [7:0] mem_mode;
    logic exp_en;
    logic fetch_en;
    logic [3:0] hi_cnt;
    logic [7:0] p5_mask;
    logic [7:0] p4_alt_out;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            p0_alt <= mpio_pkg::RST_ALT; // RL12
        end
        else if (reg_wr && reg_addr == mpio_pkg::OFF_PORT0_ALT)
        begin
            p0_alt <= reg_wdata; // RL1
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            p3_alt <= mpio_pkg::RST_ALT[4:0]; // RL12
        end
        else if (reg_wr && reg_addr == mpio_pkg::OFF_PORT3_ALT)
        begin
            p3_alt <= reg_wdata[4:0]; // RL3
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            p8_alt <= mpio_pkg::RST_ALT[5:0]; // RL12
        end
        else if (reg_wr && reg_addr == mpio_pkg::OFF_PORT8_ALT)
        begin
            p8_alt <= reg_wdata[5:0]; // RL9
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            mem_mode <= mpio_pkg::RST_MODE;
        end
        else if (reg_wr && reg_addr == mpio_pkg::OFF_MEM_MODE)
        begin
            mem_mode <= reg_wdata;
        end
    end

    assign exp_en = mem_mode[mpio_pkg::MODE_EXP_BIT];
    // fast fetch only has meaning on top of expansion
    assign fetch_en = exp_en && mem_mode[mpio_pkg::MODE_FETCH_BIT];
    assign hi_cnt = mem_mode[mpio_pkg::MODE_HICNT_MSB:mpio_pkg::MODE_HICNT_LSB];
    assign mem_exp_active = exp_en;
    assign mem_fetch_active = fetch_en;

    // upper address bits taken from the bottom up
    for (genvar i = 0; i < 8; i++)
    begin : g_hi
        assign p5_mask[i] = exp_en && (4'(i) < hi_cnt); // RL6 RL7
    end

    assign p4_alt_out = bus_addr_phase ? bus_addr[7:0] : bus_wdata; // RL5

    // ************************************************************
    // ports with output
    // ************************************************************
    logic [7:0] p0_dir, p0_rd, p4_dir, p4_rd, p5_dir, p5_rd;
    logic [4:0] p3_dir, p3_rd;
    logic [5:0] p8_dir, p8_rd;
    logic [3:0] p9_dir, p9_rd, p9_sel;

    assign p9_sel = {fetch_en, fetch_en, exp_en, exp_en}; // RL10 RL11

    mpio_port_cell #(.WIDTH(mpio_pkg::W_PORT0), .SHARED_DIR(1'b0)) u_p0 (
        .core_clk(core_clk), .rst(rst),
        .latch_we(reg_wr && reg_addr == mpio_pkg::OFF_PORT0_DATA),
        .dir_we(reg_wr && reg_addr == mpio_pkg::OFF_PORT0_DIR),
        .wdata(reg_wdata), .alt_sel(p0_alt), .alt_out(realtime_pulse_out), .alt_oe(8'hff),
        .pin_in(p0_in), .pin_out(p0_out), .pin_oe(p0_oe), .latch(), .dir(p0_dir), .rd_val(p0_rd)
    );

    mpio_port_cell #(.WIDTH(mpio_pkg::W_PORT3), .SHARED_DIR(1'b0)) u_p3 (
        .core_clk(core_clk), .rst(rst),
        .latch_we(reg_wr && reg_addr == mpio_pkg::OFF_PORT3_DATA),
        .dir_we(reg_wr && reg_addr == mpio_pkg::OFF_PORT3_DIR),
        .wdata(reg_wdata), .alt_sel(p3_alt), .alt_out(serial_ctl_out), .alt_oe(serial_ctl_oe),
        .pin_in(p3_in), .pin_out(p3_out), .pin_oe(p3_oe), .latch(), .dir(p3_dir), .rd_val(p3_rd)
    );

    mpio_port_cell #(.WIDTH(mpio_pkg::W_PORT4), .SHARED_DIR(1'b1)) u_p4 (
        .core_clk(core_clk), .rst(rst),
        .latch_we(reg_wr && reg_addr == mpio_pkg::OFF_PORT4_DATA),
        .dir_we(reg_wr && reg_addr == mpio_pkg::OFF_PORT4_DIR),
        .wdata(reg_wdata), .alt_sel({8{exp_en}}), .alt_out(p4_alt_out),
        .alt_oe({8{bus_addr_phase || bus_data_oe}}),
        .pin_in(p4_in), .pin_out(p4_out), .pin_oe(p4_oe), .latch(), .dir(p4_dir), .rd_val(p4_rd)
    );

    mpio_port_cell #(.WIDTH(mpio_pkg::W_PORT5), .SHARED_DIR(1'b0)) u_p5 (
        .core_clk(core_clk), .rst(rst),
        .latch_we(reg_wr && reg_addr == mpio_pkg::OFF_PORT5_DATA),
        .dir_we(reg_wr && reg_addr == mpio_pkg::OFF_PORT5_DIR),
        .wdata(reg_wdata), .alt_sel(p5_mask), .alt_out(bus_addr[15:8]), .alt_oe(8'hff),
        .pin_in(p5_in), .pin_out(p5_out), .pin_oe(p5_oe), .latch(), .dir(p5_dir), .rd_val(p5_rd)
    );

    mpio_port_cell #(.WIDTH(mpio_pkg::W_PORT8), .SHARED_DIR(1'b0)) u_p8 (
        .core_clk(core_clk), .rst(rst),
        .latch_we(reg_wr && reg_addr == mpio_pkg::OFF_PORT8_DATA),
        .dir_we(reg_wr && reg_addr == mpio_pkg::OFF_PORT8_DIR),
        .wdata(reg_wdata), .alt_sel(p8_alt), .alt_out({timer1_pulse_out, timer0_pulse_out}),
        .alt_oe(6'h3f),
        .pin_in(p8_in), .pin_out(p8_out), .pin_oe(p8_oe), .latch(), .dir(p8_dir), .rd_val(p8_rd)
    );

    mpio_port_cell #(.WIDTH(mpio_pkg::W_PORT9), .SHARED_DIR(1'b0)) u_p9 (
        .core_clk(core_clk), .rst(rst),
        .latch_we(reg_wr && reg_addr == mpio_pkg::OFF_PORT9_DATA),
        .dir_we(reg_wr && reg_addr == mpio_pkg::OFF_PORT9_DIR),
        .wdata(reg_wdata), .alt_sel(p9_sel),
        .alt_out({fetch_mode_out, fetch_addr_strobe, bus_wr_strobe, bus_rd_strobe}), .alt_oe(4'hf),
        .pin_in(p9_in), .pin_out(p9_out), .pin_oe(p9_oe), .latch(), .dir(p9_dir), .rd_val(p9_rd)
    );

    // ************************************************************
    // input-only ports and pin inputs toward peripherals
    // ************************************************************
    assign nmi_req = p2_in[0]; // RL2
    assign ext_irq_in = p2_in[6:1]; // RL2
    assign ext_irq_or_timer_in = p2_in[7]; // RL2
    assign analog_in = p7_in; // RL8
    assign serial_ctl_in = p3_in;
    assign bus_rdata = p4_in;

    // ************************************************************
    // register read, data valid only the cycle after the strobe
    // ************************************************************
    logic [7:0] next_rdata;

    always_comb
    begin
        next_rdata = 8'h00;
        unique case (reg_addr)
            mpio_pkg::OFF_PORT0_DATA: next_rdata = p0_rd; // RL13
            mpio_pkg::OFF_PORT0_DIR: next_rdata = p0_dir;
            mpio_pkg::OFF_PORT0_ALT: next_rdata = p0_alt;
            mpio_pkg::OFF_PORT2_DATA: next_rdata = p2_in; // RL2
            mpio_pkg::OFF_PORT3_DATA: next_rdata = {3'h0, p3_rd};
            mpio_pkg::OFF_PORT3_DIR: next_rdata = {3'h0, p3_dir};
            mpio_pkg::OFF_PORT3_ALT: next_rdata = {3'h0, p3_alt};
            mpio_pkg::OFF_PORT4_DATA: next_rdata = p4_rd;
            mpio_pkg::OFF_PORT4_DIR: next_rdata = {7'h00, p4_dir[0]};
            mpio_pkg::OFF_PORT5_DATA: next_rdata = p5_rd;
            mpio_pkg::OFF_PORT5_DIR: next_rdata = p5_dir;
            mpio_pkg::OFF_PORT7_DATA: next_rdata = p7_in; // RL8
            mpio_pkg::OFF_PORT8_DATA: next_rdata = {2'h0, p8_rd};
            mpio_pkg::OFF_PORT8_DIR: next_rdata = {2'h0, p8_dir};
            mpio_pkg::OFF_PORT8_ALT: next_rdata = {2'h0, p8_alt};
            mpio_pkg::OFF_PORT9_DATA: next_rdata = {4'h0, p9_rd};
            mpio_pkg::OFF_PORT9_DIR: next_rdata = {4'h0, p9_dir};
            mpio_pkg::OFF_MEM_MODE: next_rdata = mem_mode;
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            reg_rdata <= 8'h00;
        end
        else
        begin
            reg_rdata <= reg_rd ? next_rdata : 8'h00;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_wr(logic [7:0] a);
        reg_wr && reg_addr == a;
    endsequence

    sequence s_rd(logic [7:0] a);
        reg_rd && reg_addr == a;
    endsequence

    property p_port0_dir;
        s_wr(mpio_pkg::OFF_PORT0_DIR) ##1 (p0_alt == 8'h00)
            |-> p0_oe == $past(reg_wdata);
    endproperty
    a_port0_dir: assert property (p_port0_dir) else $error("port 0 direction not applied"); // RL1

    property p_port0_rtp;
        p0_alt == 8'hff |-> p0_out == realtime_pulse_out && p0_oe == 8'hff;
    endproperty
    a_port0_rtp: assert property (p_port0_rtp) else $error("port 0 pulse output not routed"); // RL1

    property p_port2_irq;
        {ext_irq_or_timer_in, ext_irq_in, nmi_req} == p2_in;
    endproperty
    a_port2_irq: assert property (p_port2_irq) else $error("port 2 interrupt mapping wrong"); // RL2

    property p_port3_serial;
        s_wr(mpio_pkg::OFF_PORT3_ALT) ##1 1'b1 |-> p3_oe == (($past(reg_wdata[4:0]) & serial_ctl_oe)
            | (~$past(reg_wdata[4:0]) & p3_dir));
    endproperty
    a_port3_serial: assert property (p_port3_serial) else $error("port 3 select wrong"); // RL3

    property p_port4_byte_dir;
        s_wr(mpio_pkg::OFF_PORT4_DIR) ##1 !exp_en |-> p4_oe == {8{$past(reg_wdata[0])}};
    endproperty
    a_port4_byte_dir: assert property (p_port4_byte_dir) else $error("port 4 byte direction wrong"); // RL4

    property p_port4_bus;
        exp_en && bus_addr_phase |-> p4_out == bus_addr[7:0] && p4_oe == 8'hff;
    endproperty
    a_port4_bus: assert property (p_port4_bus) else $error("port 4 address phase wrong"); // RL5

    property p_port5_addr;
        exp_en && hi_cnt == 4'h8 |-> p5_out == bus_addr[15:8] && p5_oe == 8'hff;
    endproperty
    a_port5_addr: assert property (p_port5_addr) else $error("port 5 upper address wrong"); // RL6

    property p_port5_spare;
        exp_en && hi_cnt == 4'h4 |-> p5_oe[7:4] == p5_dir[7:4] && p5_out[3:0] == bus_addr[11:8];
    endproperty
    a_port5_spare: assert property (p_port5_spare) else $error("port 5 spare bits lost"); // RL7

    property p_port7_read;
        s_rd(mpio_pkg::OFF_PORT7_DATA) |=> reg_rdata == $past(p7_in);
    endproperty
    a_port7_read: assert property (p_port7_read) else $error("port 7 read wrong"); // RL8

    property p_port8_timer;
        p8_alt == 6'h3f |-> p8_out == {timer1_pulse_out, timer0_pulse_out} && p8_oe == 6'h3f;
    endproperty
    a_port8_timer: assert property (p_port8_timer) else $error("port 8 timer output wrong"); // RL9

    property p_port9_strobe;
        exp_en |-> p9_out[1:0] == {bus_wr_strobe, bus_rd_strobe} && p9_oe[1:0] == 2'h3;
    endproperty
    a_port9_strobe: assert property (p_port9_strobe) else $error("port 9 strobes wrong"); // RL10

    property p_port9_fetch;
        s_wr(mpio_pkg::OFF_MEM_MODE) ##1 (mem_mode[1:0] == 2'h3)
            |-> p9_out[3:2] == {fetch_mode_out, fetch_addr_strobe} && p9_oe[3:2] == 2'h3;
    endproperty
    a_port9_fetch: assert property (p_port9_fetch) else $error("port 9 fetch pins wrong"); // RL11

    property p_reset_quiet;
        $past(rst) |-> (p0_oe | p4_oe | p5_oe) == 8'h00 && p3_oe == 5'h00
            && p8_oe == 6'h00 && p9_oe == 4'h0;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("pin driven after reset"); // RL12

    property p_read_back;
        s_rd(mpio_pkg::OFF_PORT0_DATA) ##0 (p0_alt == 8'h00)
            |=> reg_rdata == $past((p0_dir & p0_out) | (~p0_dir & p0_in));
    endproperty
    a_read_back: assert property (p_read_back) else $error("port 0 read-back wrong"); // RL13

endmodule

// File: logic/mpio_pkg.sv
// constants shared by the multi-port pin unit
package mpio_pkg;

    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [7:0] OFF_PORT0_DATA = 8'h00;
    localparam logic [7:0] OFF_PORT0_DIR = 8'h01;
    localparam logic [7:0] OFF_PORT0_ALT = 8'h02;
    localparam logic [7:0] OFF_PORT2_DATA = 8'h03;
    localparam logic [7:0] OFF_PORT3_DATA = 8'h04;
    localparam logic [7:0] OFF_PORT3_DIR = 8'h05;
    localparam logic [7:0] OFF_PORT3_ALT = 8'h06;
    localparam logic [7:0] OFF_PORT4_DATA = 8'h07;
    localparam logic [7:0] OFF_PORT4_DIR = 8'h08;
    localparam logic [7:0] OFF_PORT5_DATA = 8'h09;
    localparam logic [7:0] OFF_PORT5_DIR = 8'h0a;
    localparam logic [7:0] OFF_PORT7_DATA = 8'h0b;
    localparam logic [7:0] OFF_PORT8_DATA = 8'h0c;
    localparam logic [7:0] OFF_PORT8_DIR = 8'h0d;
    localparam logic [7:0] OFF_PORT8_ALT = 8'h0e;
    localparam logic [7:0] OFF_PORT9_DATA = 8'h0f;
    localparam logic [7:0] OFF_PORT9_DIR = 8'h10;
    localparam logic [7:0] OFF_MEM_MODE = 8'h11;

    // ************************************************************
    // field positions of the memory mode register
    // ************************************************************
    localparam int MODE_EXP_BIT = 0;
    localparam int MODE_FETCH_BIT = 1;
    localparam int MODE_HICNT_LSB = 4;
    localparam int MODE_HICNT_MSB = 7;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0] RST_LATCH = 8'h00;
    localparam logic [7:0] RST_DIR = 8'h00;
    localparam logic [7:0] RST_ALT = 8'h00;
    localparam logic [7:0] RST_MODE = 8'h00;

    // ************************************************************
    // port widths
    // ************************************************************
    localparam int W_PORT0 = 8;
    localparam int W_PORT2 = 8;
    localparam int W_PORT3 = 5;
    localparam int W_PORT4 = 8;
    localparam int W_PORT5 = 8;
    localparam int W_PORT7 = 8;
    localparam int W_PORT8 = 6;
    localparam int W_PORT9 = 4;

endpackage

// File: logic/mpio_port_cell.sv
// one port: output latch, direction, pin select and read-back
`timescale 1ns/1ns
module mpio_port_cell #(
    parameter int WIDTH = 8,
    parameter bit SHARED_DIR = 1'b0
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic latch_we,
    input wire logic dir_we,
    input wire logic [7:0] wdata,
    input wire logic [WIDTH-1:0] alt_sel,
    input wire logic [WIDTH-1:0] alt_out,
    input wire logic [WIDTH-1:0] alt_oe,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_out,
    output logic [WIDTH-1:0] pin_oe,
    output logic [WIDTH-1:0] latch,
    output logic [WIDTH-1:0] dir,
    output logic [WIDTH-1:0] rd_val
);

    // ************************************************************
    // output latch and direction
    // ************************************************************
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            latch <= WIDTH'(mpio_pkg::RST_LATCH);
        end
        else if (latch_we)
        begin
            latch <= wdata[WIDTH-1:0];
        end
    end

    // shared direction takes bit 0 for the whole port
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            dir <= WIDTH'(mpio_pkg::RST_DIR); // RL12
        end
        else if (dir_we)
        begin
            dir <= SHARED_DIR ? {WIDTH{wdata[0]}} : wdata[WIDTH-1:0]; // RL4
        end
    end

    // ************************************************************
    // pin muxing per bit
    // ************************************************************
    for (genvar i = 0; i < WIDTH; i++)
    begin : g_bit
        assign pin_out[i] = alt_sel[i] ? alt_out[i] : latch[i];
        assign pin_oe[i] = alt_sel[i] ? alt_oe[i] : dir[i];
        assign rd_val[i] = (!alt_sel[i] && dir[i]) ? latch[i] : pin_in[i]; // RL13
    end

endmodule

// File: tb/mpio_pin_model.sv
// board-side pin model for one port: level seen at the pin
`timescale 1ns/1ns
module mpio_pin_model #(
    parameter int W = 8
) (
    input wire logic [W-1:0] drv,
    input wire logic [W-1:0] en,
    input wire logic [W-1:0] ext,
    output logic [W-1:0] level
);
    // released pins show the board value, not the last driven one
    assign level = (en & drv) | (~en & ext);
endmodule

// File: tb/mpio_port_unit_tb.sv
// self-checking bench for the multi-port pin unit
`timescale 1ns/1ns
module mpio_port_unit_tb;
    logic core_clk, rst, reg_wr, reg_rd, rd_d, nmi_req, ext_irq_or_timer_in, bus_addr_phase, bus_data_oe;
    logic bus_rd_strobe, bus_wr_strobe, fetch_addr_strobe, fetch_mode_out, mem_exp_active, mem_fetch_active;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, p0_in, p0_out, p0_oe, p2_in, p4_in, p4_out, p4_oe;
    logic [7:0] p5_in, p5_out, p5_oe, p7_in, realtime_pulse_out, analog_in, bus_wdata, bus_rdata, e0, e4, e5;
    logic [4:0] p3_in, p3_out, p3_oe, serial_ctl_out, serial_ctl_oe, serial_ctl_in, e3;
    logic [5:0] p8_in, p8_out, p8_oe, ext_irq_in, e8;
    logic [3:0] p9_in, p9_out, p9_oe, timer0_pulse_out, e9;
    logic [1:0] timer1_pulse_out;
    logic [15:0] bus_addr;
    logic [7:0] expq[$];
    int miscompares, comparisons;

    mpio_port_unit uut (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .p0_in, .p0_out, .p0_oe, .p2_in, .p3_in, .p3_out, .p3_oe, .p4_in, .p4_out, .p4_oe,
        .p5_in, .p5_out, .p5_oe, .p7_in, .p8_in, .p8_out, .p8_oe, .p9_in, .p9_out, .p9_oe,
        .realtime_pulse_out, .nmi_req, .ext_irq_in, .ext_irq_or_timer_in, .analog_in,
        .serial_ctl_out, .serial_ctl_oe, .serial_ctl_in, .timer0_pulse_out, .timer1_pulse_out,
        .bus_addr, .bus_wdata, .bus_addr_phase, .bus_data_oe, .bus_rdata, .bus_rd_strobe,
        .bus_wr_strobe, .fetch_addr_strobe, .fetch_mode_out, .mem_exp_active, .mem_fetch_active);

    mpio_pin_model #(.W(8)) m0 (.drv(p0_out), .en(p0_oe), .ext(e0), .level(p0_in));
    mpio_pin_model #(.W(5)) m3 (.drv(p3_out), .en(p3_oe), .ext(e3), .level(p3_in));
    mpio_pin_model #(.W(8)) m4 (.drv(p4_out), .en(p4_oe), .ext(e4), .level(p4_in));
    mpio_pin_model #(.W(8)) m5 (.drv(p5_out), .en(p5_oe), .ext(e5), .level(p5_in));
    mpio_pin_model #(.W(6)) m8 (.drv(p8_out), .en(p8_oe), .ext(e8), .level(p8_in));
    mpio_pin_model #(.W(4)) m9 (.drv(p9_out), .en(p9_oe), .ext(e9), .level(p9_in));

    // ************************************************************
    // tasks
    // ************************************************************
    task automatic results();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        expq.push_back(exp);
        @(posedge core_clk);
        reg_rd <= 1'b0;
    endtask

    task automatic settle();
        @(negedge core_clk);
    endtask

    // read-back: latch for plain outputs, pin level otherwise
    function automatic logic [7:0] rdv(input logic [7:0] s, d, l, aoe, aout, ext);
        logic [7:0] oe, pin;
        oe = (s & aoe) | (~s & d);
        pin = (oe & ((s & aout) | (~s & l))) | (~oe & ext);
        return (~s & d & l) | (~(~s & d) & pin);
    endfunction

    // read data stands only in the cycle after the strobe
    always @(posedge core_clk) rd_d <= reg_rd;
    always @(negedge core_clk)
        if (rd_d === 1'b1)
            check("reg_rdata", reg_rdata, expq.pop_front());
        else if (rst === 1'b0)
            check("rdata_idle", reg_rdata, 8'h00);

    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    initial
    begin
        repeat (20000) @(posedge core_clk);
        miscompares++;
        results();
    end

    // ************************************************************
    // main sequence
    // ************************************************************
    initial
    begin
        logic [7:0] l, d, s, m, v;
        rst = 1'b1;
        {reg_addr, reg_wdata, reg_wr, reg_rd, p2_in, p7_in, realtime_pulse_out} = '0;
        {serial_ctl_out, serial_ctl_oe, timer0_pulse_out, timer1_pulse_out, bus_addr, bus_wdata} = '0;
        {bus_addr_phase, bus_data_oe, bus_rd_strobe, bus_wr_strobe, fetch_addr_strobe, fetch_mode_out} = '0;
        {e0, e3, e4, e5, e8, e9} = '0;
        miscompares = 0;
        comparisons = 0;
        void'($urandom(32'h34ee));
        {e0, e3, e4, e5, e8, e9} = 39'({$urandom, $urandom});
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        settle();
        check("oe_reset", {p0_oe, p3_oe, p4_oe, p5_oe}, 0);
        check("out_reset", {p0_out, p3_out, p4_out, p5_out}, 0);
        check("p8_p9_reset", {p8_oe, p9_oe, p8_out, p9_out}, 0);
        for (int a = 1; a <= 8'h11; a += 1)
            if (a inside {1, 2, 5, 6, 8, 8'h0a, 8'h0d, 8'h0e, 8'h10, 8'h11})
                rd(8'(a), 8'h00);
        $display("test reset done");
        l = $urandom;
        d = $urandom;
        wr(8'h00, l);
        wr(8'h01, d);
        settle();
        check("p0_oe", p0_oe, d);
        check("p0_out", p0_out, l);
        rd(8'h00, rdv(8'h00, d, l, 8'h00, 8'h00, e0));
        s = $urandom;
        realtime_pulse_out <= 8'($urandom);
        wr(8'h02, s);
        settle();
        check("p0_alt", p0_out, (s & realtime_pulse_out) | (~s & l));
        rd(8'h02, s);
        $display("test port0 done");
        p2_in <= $urandom;
        p7_in <= $urandom;
        wr(8'h03, 8'h5a);
        wr(8'h0b, 8'ha5);
        settle();
        check("irq_pins", {ext_irq_or_timer_in, ext_irq_in, nmi_req}, p2_in);
        check("analog_in", analog_in, p7_in);
        rd(8'h03, p2_in);
        rd(8'h0b, p7_in);
        rd(8'h12, 8'h00);
        rd(8'hff, 8'h00);
        $display("test input ports done");
        {l, d, s} = {$urandom, $urandom};
        {serial_ctl_out, serial_ctl_oe} <= 10'($urandom);
        wr(8'h04, l[4:0]);
        wr(8'h05, d[4:0]);
        wr(8'h06, s[4:0]);
        settle();
        check("p3_oe", p3_oe, (s[4:0] & serial_ctl_oe) | (~s[4:0] & d[4:0]));
        check("p3_out", p3_out, (s[4:0] & serial_ctl_out) | (~s[4:0] & l[4:0]));
        check("serial_in", serial_ctl_in, p3_in);
        rd(8'h04, rdv(s[4:0], d[4:0], l[4:0], serial_ctl_oe, serial_ctl_out, e3));
        {l, d, s} = {$urandom, $urandom};
        {timer1_pulse_out, timer0_pulse_out} <= 6'($urandom);
        wr(8'h0c, l[5:0]);
        wr(8'h0d, d[5:0]);
        wr(8'h0e, s[5:0]);
        settle();
        check("p8_oe", p8_oe, s[5:0] | d[5:0]);
        check("p8_out", p8_out, (s[5:0] & {timer1_pulse_out, timer0_pulse_out}) | (~s[5:0] & l[5:0]));
        rd(8'h0c, rdv(s[5:0], d[5:0], l[5:0], 6'h3f, {timer1_pulse_out, timer0_pulse_out}, e8));
        $display("test port3 port8 done");
        l = $urandom;
        wr(8'h07, l);
        wr(8'h08, 8'h01);
        settle();
        check("p4_oe_all", {p4_oe, p4_out}, {8'hff, l});
        rd(8'h07, l);
        wr(8'h08, 8'hfe);
        settle();
        check("p4_oe_none", p4_oe, 8'h00);
        rd(8'h07, e4);
        d = $urandom;
        wr(8'h10, d[3:0]);
        wr(8'h11, 8'h01);
        @(posedge core_clk);
        {bus_addr, bus_wdata} <= 24'($urandom);
        {bus_addr_phase, bus_data_oe} <= 2'b10;
        {bus_rd_strobe, bus_wr_strobe} <= 2'($urandom);
        settle();
        check("exp_active", {mem_exp_active, mem_fetch_active}, 2'b10);
        check("p4_addr", {p4_oe, p4_out}, {8'hff, bus_addr[7:0]});
        check("p9_strobe", {p9_oe[1:0], p9_out[1:0]}, {2'b11, bus_wr_strobe, bus_rd_strobe});
        @(posedge core_clk);
        bus_addr_phase <= 1'b0;
        settle();
        check("p4_idle", {p4_oe, bus_rdata}, {8'h00, e4});
        @(posedge core_clk);
        bus_data_oe <= 1'b1;
        {bus_rd_strobe, bus_wr_strobe} <= ~{bus_rd_strobe, bus_wr_strobe};
        settle();
        check("p4_data", {p4_oe, p4_out}, {8'hff, bus_wdata});
        check("p9_strobe2", p9_out[1:0], {bus_wr_strobe, bus_rd_strobe});
        @(posedge core_clk);
        {fetch_addr_strobe, fetch_mode_out} <= 2'($urandom);
        wr(8'h11, 8'h03);
        settle();
        check("fetch_on", {mem_fetch_active, p9_oe[3:2]}, 3'b111);
        check("fetch_pins", p9_out[3:2], {fetch_mode_out, fetch_addr_strobe});
        wr(8'h11, 8'h02);
        settle();
        check("fetch_no_exp", {mem_exp_active, mem_fetch_active, p9_oe}, {2'b00, d[3:0]});
        $display("test port4 port9 done");
        l = $urandom;
        d = $urandom;
        wr(8'h09, l);
        wr(8'h0a, d);
        for (int n = 0; n <= 9; n++)
        begin
            v = 8'(n);
            wr(8'h11, {v[3:0], 4'h1});
            settle();
            m = (n >= 8) ? 8'hff : 8'((1 << n) - 1);
            check("p5_oe", p5_oe, m | d);
            check("p5_out", p5_out, (m & bus_addr[15:8]) | (~m & l));
        end
        $display("test port5 done");
        @(posedge core_clk);
        rst <= 1'b1;
        @(posedge core_clk);
        rst <= 1'b0;
        settle();
        check("oe_rereset", {p0_oe, p3_oe, p4_oe, p5_oe, p8_oe[1:0]}, 0);
        check("mode_rereset", {mem_exp_active, p9_oe, p8_oe}, 0);
        $display("test second reset done");
        repeat (2) @(posedge core_clk);
        results();
    end
endmodule
